// *** src/settings_menu.sv ***
// front-panel settings menu: levels, parameter views, working copy and stored values
// assumes active-low key pins and one 100 MHz clock; lockout and variant are static straps
`timescale 1ns/1ns

// Summary of operation
// [R1] operation level, level key 3 s: initial
// [R2] initial level, level key 1 s: operation
// [R3] advanced: 1 s hold initial, again operation
// [R4] shift shows value, second shift edits
// [R5] short level press commits and advances
// [R6] temperature unit: Celsius or Fahrenheit
// [R7] outputs 1,2 action: upper, lower, outside
// [R8] order: output 1, output 2, menu
// [R9] setpoints: one, or upper and lower
// [R10] temperature variant hides output 2 params
// [R11] password opens advanced level, code F
// [R12] clear-all first advanced, reads off
// [R13] clear-all shown only with lockout zero
// [R14] clear-all on restores factory defaults
// [R15] averaging: off, 2, 4 or 8
// [R16] per-output hysteresis 0 to 9999
// [R17] stored zero hysteresis acts as one
// [R18] output 2 hysteresis follows output 1
// [R19] keys debounced; holds counted; short under 1 s
// [R20] edits kept in working copy until commit
module settings_menu
    import menu_pkg::*;
#(
    parameter int unsigned DEBOUNCE = DEBOUNCE_TICKS,
    parameter int unsigned HOLD1    = LEAVE_TICKS,
    parameter int unsigned HOLD3    = ENTER_TICKS
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        key_level_n_i,
    input  wire logic        key_shift_n_i,
    input  wire logic        key_up_n_i,
    input  wire logic        temp_variant_i,
    input  wire logic        lockout_zero_i,
    output logic [3:0]       level_code_o,
    output logic [3:0]       param_o,
    output logic             show_value_o,
    output logic             blink_o,
    output logic [13:0]      value_o,
    output logic             value_neg_o,
    output logic             temp_unit_f_o,
    output logic [1:0]       out1_action_o,
    output logic [1:0]       out2_action_o,
    output logic [1:0]       averaging_count_o,
    output logic [13:0]      compare_hysteresis1_o,
    output logic [13:0]      compare_hysteresis2_o,
    output logic             out1_split_sp_o,
    output logic             out2_split_sp_o
);
    // ************************************************************
    // key conditioning
    // ************************************************************
    key_events_if keys ();

    key_conditioner #(
        .DEBOUNCE (DEBOUNCE),
        .HOLD1    (HOLD1),
        .HOLD3    (HOLD3)
    ) u_keys (
        .clock_i  (clock_i),
        .rst_n_i  (rst_n_i),
        .key_n_i  ({key_up_n_i, key_shift_n_i, key_level_n_i}),
        .ev       (keys.source)
    );

    // ************************************************************
    // straps, caught after reset through two flops
    // ************************************************************
    typedef struct packed {
        logic [1:0]  strap1;
        logic [1:0]  strap2;
        level_e      level;
        view_e       view;
        param_e      param;
        logic [13:0] work;
        logic        work_neg;
        logic        unit_f;
        logic [1:0]  act1;
        logic [1:0]  act2;
        logic [1:0]  averaging_count;
        logic [13:0] hyst1;
        logic [13:0] hyst2;
        logic [3:0]  level_code;
        logic [13:0] value;
        logic        value_neg;
        logic [13:0] hyst1_eff;
        logic [13:0] hyst2_eff;
        logic        show;
        logic        blink;
    } menu_s;

    menu_s state_reg;
    menu_s state_next;

    // stored value of a parameter, as shown in the monitor state
    function automatic logic [13:0] stored_value(input param_e p, input menu_s s);
        case (p)
            PARAM_UNIT:  stored_value = {13'h0000, s.unit_f};
            PARAM_OUT1:  stored_value = {12'h000, s.act1};
            PARAM_OUT2:  stored_value = {12'h000, s.act2};
            PARAM_AVG:   stored_value = {12'h000, s.averaging_count};
            PARAM_HYST1: stored_value = s.hyst1;
            PARAM_HYST2: stored_value = s.hyst2;
            default:     stored_value = 14'h0000;
        endcase
    endfunction

    // wrap limit of the up key for each parameter
    function automatic logic [13:0] value_max(input param_e p);
        case (p)
            PARAM_UNIT:  value_max = 14'h0001;
            PARAM_OUT1:  value_max = 14'h0002;
            PARAM_OUT2:  value_max = 14'h0002;
            PARAM_CLEAR: value_max = 14'h0001;
            PARAM_AVG:   value_max = 14'h0003;
            PARAM_MENU:  value_max = 14'h0fff;
            default:     value_max = HYST_MAX;
        endcase
    endfunction

    // first parameter of the advanced level
    function automatic param_e adv_first(input logic lock0);
        adv_first = lock0 ? PARAM_CLEAR : PARAM_AVG;  // see [R12] see [R13]
    endfunction

    // ************************************************************
    // menu state machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        state_next.strap1 = {temp_variant_i, lockout_zero_i};
        state_next.strap2 = state_reg.strap1;
        case (state_reg.level)
            LEVEL_OPER: begin
                if (keys.level_hold3) begin  // see [R1]
                    state_next.level = LEVEL_INIT;
                    state_next.view  = VIEW_NAME;
                    state_next.param = PARAM_UNIT;
                end
            end
            LEVEL_INIT, LEVEL_ADV: begin
                if (keys.level_hold1) begin
                    // see [R2] see [R3]
                    state_next.level = (state_reg.level == LEVEL_ADV) ? LEVEL_INIT : LEVEL_OPER;
                    state_next.view  = VIEW_NAME;  // see [R20]
                    state_next.param = PARAM_UNIT;
                end else if (keys.shift_press) begin
                    case (state_reg.view)
                        VIEW_NAME: begin
                            state_next.view = VIEW_MONITOR;  // see [R4]
                        end
                        VIEW_MONITOR: begin
                            state_next.view     = VIEW_CHANGE;  // see [R4]
                            state_next.work     = stored_value(state_reg.param, state_reg);
                            state_next.work_neg = (state_reg.param == PARAM_MENU);
                        end
                        default: begin
                        end
                    endcase
                end else if (keys.up_press && state_reg.view == VIEW_CHANGE) begin
                    if (state_reg.work >= value_max(state_reg.param)) begin
                        state_next.work = 14'h0000;
                    end else begin
                        state_next.work = state_reg.work + 14'h0001;  // see [R16]
                    end
                end else if (keys.level_short) begin
                    state_next.view = VIEW_NAME;
                    if (state_reg.view == VIEW_CHANGE) begin
                        case (state_reg.param)  // see [R5] see [R20]
                            PARAM_UNIT:  state_next.unit_f = state_reg.work[0];  // see [R6]
                            PARAM_OUT1:  state_next.act1   = state_reg.work[1:0];  // see [R7]
                            PARAM_OUT2:  state_next.act2   = state_reg.work[1:0];
                            PARAM_AVG:   state_next.averaging_count    = state_reg.work[1:0];  // see [R15]
                            PARAM_HYST1: state_next.hyst1  = state_reg.work;
                            PARAM_HYST2: state_next.hyst2  = state_reg.work;
                            PARAM_CLEAR: begin
                                if (state_reg.work[0]) begin  // see [R14]
                                    state_next.unit_f = UNIT_RESET;
                                    state_next.act1   = ACTION_RESET;
                                    state_next.act2   = ACTION_RESET;
                                    state_next.averaging_count    = AVG_RESET;
                                    state_next.hyst1  = HYST_RESET;
                                    state_next.hyst2  = HYST_RESET;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    case (state_reg.param)
                        PARAM_UNIT:  state_next.param = PARAM_OUT1;
                        PARAM_OUT1:  begin
                            // see [R8] see [R10]
                            state_next.param = state_reg.strap2[1] ? PARAM_MENU : PARAM_OUT2;
                        end
                        PARAM_OUT2:  state_next.param = PARAM_MENU;  // see [R8]
                        PARAM_MENU:  begin
                            if (state_reg.view == VIEW_CHANGE && state_reg.work_neg &&
                                state_reg.work == (state_reg.strap2[1] ? PASSWORD_TEMP
                                                                       : PASSWORD_FULL)) begin
                                state_next.level = LEVEL_ADV;  // see [R11]
                                state_next.param = adv_first(state_reg.strap2[0]);
                            end else begin
                                state_next.param = PARAM_UNIT;
                            end
                        end
                        PARAM_CLEAR: state_next.param = PARAM_AVG;
                        PARAM_AVG:   state_next.param = PARAM_HYST1;
                        PARAM_HYST1: begin
                            // see [R18] see [R10]
                            state_next.param = state_reg.strap2[1] ? adv_first(state_reg.strap2[0])
                                                                   : PARAM_HYST2;
                        end
                        PARAM_HYST2: state_next.param = adv_first(state_reg.strap2[0]);
                        default:     state_next.param = PARAM_UNIT;
                    endcase
                end
            end
            default: begin
                state_next.level = LEVEL_OPER;
                state_next.param = PARAM_UNIT;
            end
        endcase
        case (state_next.level)
            LEVEL_INIT: state_next.level_code = LEVEL_CODE_INIT;  // see [R1]
            LEVEL_ADV:  state_next.level_code = LEVEL_CODE_ADV;   // see [R11]
            default:    state_next.level_code = LEVEL_CODE_OPER;
        endcase
        if (state_next.view == VIEW_CHANGE) begin
            state_next.value     = state_next.work;
            state_next.value_neg = state_next.work_neg;
        end else begin
            // clear-all reads off when shown outside the change view
            state_next.value     = stored_value(state_next.param, state_next);  // see [R12]
            state_next.value_neg = 1'b0;
        end
        state_next.show  = (state_next.view != VIEW_NAME);  // see [R4]
        state_next.blink = (state_next.view == VIEW_CHANGE);  // see [R4]
        // see [R17]
        state_next.hyst1_eff = (state_next.hyst1 == 14'h0000) ? 14'h0001 : state_next.hyst1;
        state_next.hyst2_eff = (state_next.hyst2 == 14'h0000) ? 14'h0001 : state_next.hyst2;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg            <= '0;
            state_reg.level      <= LEVEL_OPER;
            state_reg.view       <= VIEW_NAME;
            state_reg.param      <= PARAM_UNIT;
            state_reg.unit_f     <= UNIT_RESET;
            state_reg.act1       <= ACTION_RESET;
            state_reg.act2       <= ACTION_RESET;
            state_reg.averaging_count        <= AVG_RESET;
            state_reg.hyst1      <= HYST_RESET;
            state_reg.hyst2      <= HYST_RESET;
            state_reg.level_code <= LEVEL_CODE_OPER;
            state_reg.hyst1_eff  <= 14'h0001;
            state_reg.hyst2_eff  <= 14'h0001;
        end else begin
            state_reg <= state_next;
        end
    end

    // ************************************************************
    // outputs, all from flops
    // ************************************************************
    assign level_code_o          = state_reg.level_code;
    assign param_o               = state_reg.param;
    assign show_value_o          = state_reg.show;
    assign blink_o               = state_reg.blink;
    assign value_o               = state_reg.value;
    assign value_neg_o           = state_reg.value_neg;
    assign temp_unit_f_o         = state_reg.unit_f;
    assign out1_action_o         = state_reg.act1;
    assign out2_action_o         = state_reg.act2;
    assign averaging_count_o     = state_reg.averaging_count;
    assign compare_hysteresis1_o = state_reg.hyst1_eff;
    assign compare_hysteresis2_o = state_reg.hyst2_eff;
    assign out1_split_sp_o       = state_reg.act1[1];  // see [R9]
    assign out2_split_sp_o       = state_reg.act2[1];  // see [R9]
endmodule

// *** src/menu_pkg.sv ***
// constants and types for the settings menu
// assumes a 100 MHz system clock
package menu_pkg;
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned DEBOUNCE_MS    = 10;
    localparam int unsigned ENTER_HOLD_S   = 3;
    localparam int unsigned LEAVE_HOLD_S   = 1;
    localparam int unsigned DEBOUNCE_TICKS = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned ENTER_TICKS    = CLK_HZ * ENTER_HOLD_S;
    localparam int unsigned LEAVE_TICKS    = CLK_HZ * LEAVE_HOLD_S;

    localparam logic [3:0] LEVEL_CODE_OPER = 4'h0;
    localparam logic [3:0] LEVEL_CODE_INIT = 4'h5;
    localparam logic [3:0] LEVEL_CODE_ADV  = 4'hf;

    localparam logic [13:0] PASSWORD_FULL  = 14'h00a9;
    localparam logic [13:0] PASSWORD_TEMP  = 14'h00a9;
    localparam logic [13:0] HYST_MAX       = 14'h270f;

    localparam logic       UNIT_RESET   = 1'b0;
    localparam logic [1:0] ACTION_RESET = 2'h0;
    localparam logic [1:0] AVG_RESET    = 2'h0;
    localparam logic [13:0] HYST_RESET  = 14'h0000;

    typedef enum logic [1:0] {
        LEVEL_OPER = 2'b00,
        LEVEL_INIT = 2'b01,
        LEVEL_ADV  = 2'b10
    } level_e;

    typedef enum logic [1:0] {
        VIEW_NAME    = 2'b00,
        VIEW_MONITOR = 2'b01,
        VIEW_CHANGE  = 2'b10
    } view_e;

    typedef enum logic [3:0] {
        PARAM_UNIT    = 4'h0,
        PARAM_OUT1    = 4'h1,
        PARAM_OUT2    = 4'h2,
        PARAM_MENU    = 4'h3,
        PARAM_CLEAR   = 4'h4,
        PARAM_AVG     = 4'h5,
        PARAM_HYST1   = 4'h6,
        PARAM_HYST2   = 4'h7,
        PARAM_SP      = 4'h8
    } param_e;
endpackage

// *** src/key_events_if.sv ***
// events from the key conditioner to the menu core
// assumes one clock domain
`timescale 1ns/1ns
interface key_events_if;
    logic level_short;
    logic level_hold1;
    logic level_hold3;
    logic shift_press;
    logic up_press;
    modport source (output level_short, level_hold1, level_hold3, shift_press, up_press);
    modport sink   (input  level_short, level_hold1, level_hold3, shift_press, up_press);
endinterface

// *** src/key_conditioner.sv ***
// synchronises and debounces the three front-panel keys, and times holds of the level key
// assumes raw active-low key pins, one system clock
`timescale 1ns/1ns
module key_conditioner
    import menu_pkg::*;
#(
    parameter int unsigned DEBOUNCE = DEBOUNCE_TICKS,
    parameter int unsigned HOLD1    = LEAVE_TICKS,
    parameter int unsigned HOLD3    = ENTER_TICKS
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic [2:0]  key_n_i,
    key_events_if.source     ev
);
    if (HOLD1 < 2 || HOLD3 <= HOLD1 || DEBOUNCE < 1 || DEBOUNCE > 32'h0010_0000) begin
        $error("bad key timing parameters");
    end

    typedef struct packed {
        logic [2:0]  sync1;
        logic [2:0]  sync2;
        logic [2:0]  stable;
        logic [2:0][19:0] bounce;
        logic [31:0] hold;
        logic        fired1;
        logic        fired3;
        logic        level_short;
        logic        level_hold1;
        logic        level_hold3;
        logic        shift_press;
        logic        up_press;
    } cond_s;

    cond_s state_reg;
    cond_s state_next;

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = ~key_n_i;
        state_next.sync2 = state_reg.sync1;
        state_next.level_short = 1'b0;
        state_next.level_hold1 = 1'b0;
        state_next.level_hold3 = 1'b0;
        state_next.shift_press = 1'b0;
        state_next.up_press    = 1'b0;
        for (int k = 0; k < 3; k++) begin
            if (state_reg.sync2[k] == state_reg.stable[k]) begin
                state_next.bounce[k] = 20'h00000;
            end else if (state_reg.bounce[k] >= 20'(DEBOUNCE - 1)) begin  // see [R19]
                state_next.bounce[k] = 20'h00000;
                state_next.stable[k] = state_reg.sync2[k];
            end else begin
                state_next.bounce[k] = state_reg.bounce[k] + 20'h00001;
            end
        end
        state_next.shift_press = state_next.stable[1] & ~state_reg.stable[1];
        state_next.up_press    = state_next.stable[2] & ~state_reg.stable[2];
        if (state_reg.stable[0]) begin
            if (state_reg.hold != 32'hffffffff) begin
                state_next.hold = state_reg.hold + 32'h1;
            end
            if (state_reg.hold == 32'(HOLD1 - 1)) begin  // see [R19]
                state_next.level_hold1 = 1'b1;
                state_next.fired1      = 1'b1;
            end
            if (state_reg.hold == 32'(HOLD3 - 1)) begin
                state_next.level_hold3 = 1'b1;
                state_next.fired3      = 1'b1;
            end
            if (!state_next.stable[0] && !state_reg.fired1) begin
                state_next.level_short = 1'b1;  // see [R19]
            end
        end
        if (!state_next.stable[0]) begin
            state_next.hold   = 32'h0;
            state_next.fired1 = 1'b0;
            state_next.fired3 = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign ev.level_short = state_reg.level_short;
    assign ev.level_hold1 = state_reg.level_hold1;
    assign ev.level_hold3 = state_reg.level_hold3;
    assign ev.shift_press = state_reg.shift_press;
    assign ev.up_press    = state_reg.up_press;
endmodule

// *** testbench/operator_keys.sv ***
// operator model: presses the three front-panel keys for set numbers of cycles
// assumes the bench clock; released keys read high
`timescale 1ns/1ns
module operator_keys (
    input  wire logic clock_i,
    output logic      key_level_n_o,
    output logic      key_shift_n_o,
    output logic      key_up_n_o
);
    // ****************
    // key pins
    // ****************
    logic [2:0] keys_n_reg = 3'h7;
    assign {key_up_n_o, key_shift_n_o, key_level_n_o} = keys_n_reg;
    // hold key k low for n cycles, then leave a settling gap
    task automatic press(input int k, input int n);
        @(posedge clock_i);
        keys_n_reg[k] <= 1'b0;
        repeat (n) @(posedge clock_i);
        keys_n_reg[k] <= 1'b1;
        repeat (16) @(posedge clock_i);
    endtask
endmodule

// *** testbench/settings_menu_checker.sv ***
// port-level assertions for the settings menu
// assumes binding onto settings_menu, one clock, async active-low reset
`timescale 1ns/1ns
module settings_menu_checker
    import menu_pkg::*;
#(
    parameter int unsigned DEBOUNCE = DEBOUNCE_TICKS,
    parameter int unsigned HOLD1    = LEAVE_TICKS,
    parameter int unsigned HOLD3    = ENTER_TICKS
) (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        temp_variant_i,
    input wire logic        lockout_zero_i,
    input wire logic [3:0]  level_code_o,
    input wire logic [3:0]  param_o,
    input wire logic        show_value_o,
    input wire logic        blink_o,
    input wire logic        temp_unit_f_o,
    input wire logic [1:0]  out1_action_o,
    input wire logic [1:0]  averaging_count_o,
    input wire logic [13:0] compare_hysteresis1_o,
    input wire logic [13:0] compare_hysteresis2_o,
    input wire logic        out1_split_sp_o
);
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    property p_init_entry;
        level_code_o == 4'h5 && $past(level_code_o) == 4'h0 |-> param_o == 4'h0;
    endproperty
    a_init_entry: assert property (p_init_entry) else $error("init entry param");
    property p_adv_entry;
        $changed(level_code_o) && level_code_o == 4'hf |-> $past(param_o) == PARAM_MENU;
    endproperty
    a_adv_entry: assert property (p_adv_entry) else $error("adv entry source");
    property p_oper_quiet;
        level_code_o == 4'h0 |-> param_o == 4'h0 && !show_value_o;
    endproperty
    a_oper_quiet: assert property (p_oper_quiet) else $error("operation view");
    property p_blink_show;
        blink_o |-> show_value_o;
    endproperty
    a_blink_show: assert property (p_blink_show) else $error("blink without value");
    property p_hyst_range;
        compare_hysteresis1_o inside {[14'h0001:14'h270f]};
    endproperty
    a_hyst_range: assert property (p_hyst_range) else $error("hysteresis1 range");
    property p_hyst2_range;
        compare_hysteresis2_o inside {[14'h0001:14'h270f]};
    endproperty
    a_hyst2_range: assert property (p_hyst2_range) else $error("hysteresis2 range");
    property p_split;
        out1_split_sp_o == (out1_action_o == 2'h2) && out1_action_o != 2'h3;
    endproperty
    a_split: assert property (p_split) else $error("split setpoint flag");
    property p_commit_only;
        $changed(averaging_count_o) || $changed(temp_unit_f_o) |-> $past(blink_o);
    endproperty
    a_commit_only: assert property (p_commit_only) else $error("setting moved");
    property p_hidden;
        (temp_variant_i |-> param_o != PARAM_OUT2 && param_o != PARAM_HYST2)
            and (!lockout_zero_i |-> param_o != PARAM_CLEAR);
    endproperty
    a_hidden: assert property (p_hidden) else $error("hidden parameter shown");
    c_init: cover property (level_code_o == 4'h5);
    c_adv: cover property (level_code_o == 4'hf);
    c_edit: cover property (blink_o);
endmodule

bind settings_menu settings_menu_checker #(.DEBOUNCE(DEBOUNCE), .HOLD1(HOLD1), .HOLD3(HOLD3))
    u_settings_menu_checker (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .temp_variant_i(temp_variant_i), .lockout_zero_i(lockout_zero_i),
    .level_code_o(level_code_o), .param_o(param_o), .show_value_o(show_value_o),
    .blink_o(blink_o), .temp_unit_f_o(temp_unit_f_o), .out1_action_o(out1_action_o),
    .averaging_count_o(averaging_count_o), .compare_hysteresis1_o(compare_hysteresis1_o),
    .compare_hysteresis2_o(compare_hysteresis2_o), .out1_split_sp_o(out1_split_sp_o));

// *** testbench/testbench.sv ***
// self-checking bench for the settings menu
// assumes shortened key timing 4/20/60 cycles and the operator model
`timescale 1ns/1ns
module testbench;
    import menu_pkg::*;
    // ****************
    // signals
    // ****************
    localparam int LVL = 0, SFT = 1, UPK = 2, SHORT = 10, HOLD = 30, LONG = 80;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        temp_v  = 1'b0;
    logic        lock_z  = 1'b1;
    logic        kl_n, ks_n, ku_n, show, blink, neg, unit_f, split1, split2;
    logic [3:0]  level, param;
    logic [13:0] value, hyst1, hyst2;
    logic [1:0]  act1, act2, averaging_count;
    int          n_mismatch = 0;
    int          comparisons = 0;
    initial forever #5 clock_i = ~clock_i;
    operator_keys u_operator_keys (.clock_i(clock_i), .key_level_n_o(kl_n),
        .key_shift_n_o(ks_n), .key_up_n_o(ku_n));
    settings_menu #(.DEBOUNCE(4), .HOLD1(20), .HOLD3(60)) u_settings_menu (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .key_level_n_i(kl_n), .key_shift_n_i(ks_n),
        .key_up_n_i(ku_n), .temp_variant_i(temp_v), .lockout_zero_i(lock_z),
        .level_code_o(level), .param_o(param), .show_value_o(show), .blink_o(blink),
        .value_o(value), .value_neg_o(neg), .temp_unit_f_o(unit_f), .out1_action_o(act1),
        .out2_action_o(act2), .averaging_count_o(averaging_count), .compare_hysteresis1_o(hyst1),
        .compare_hysteresis2_o(hyst2), .out1_split_sp_o(split1), .out2_split_sp_o(split2));
    // ****************
    // helpers
    // ****************
    task automatic chk(input string what, input logic [13:0] e, input logic [13:0] g);
        comparisons++;
        if (e !== g) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic key(input int k, input int n);
        u_operator_keys.press(k, n);
    endtask
    task automatic commit(input int n);
        key(SFT, SHORT);
        key(SFT, SHORT);
        repeat (n) key(UPK, SHORT);
        chk("blink", 14'h1, {13'h0, blink});
        key(LVL, SHORT);
    endtask
    task automatic do_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
    endtask
    task automatic give_verdict();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_enter();
        chk("hyst1 default", 14'h1, hyst1);
        chk("avg default", 14'h0, {12'h0, averaging_count});
        key(LVL, SHORT);
        chk("short ignored", 14'h0, {10'h0, level});
        key(LVL, LONG);
        chk("init level", 14'h5, {10'h0, level});
        chk("first param", 14'h0, {10'h0, param});
    endtask
    task automatic t_init_pass();
        key(SFT, SHORT);
        chk("monitor", 14'h2, {12'h0, show, blink});
        key(SFT, SHORT);
        key(UPK, SHORT);
        chk("working copy", 14'h1, value);
        key(LVL, SHORT);
        chk("unit f", 14'h1, {13'h0, unit_f});
        chk("advance", 14'h1, {10'h0, param});
        commit(2);
        chk("out1 outside", 14'h5, {11'h0, act1, split1});
        commit(1);
        chk("out2 lower", 14'h2, {11'h0, act2, split2});
        chk("menu next", 14'h3, {10'h0, param});
    endtask
    task automatic t_adv();
        key(SFT, SHORT);
        key(SFT, SHORT);
        chk("password sign", 14'h3, {12'h0, neg, blink});
        key(UPK, SHORT);
        key(LVL, SHORT);
        chk("wrong password", 14'h50, {6'h0, level, param});
        repeat (3) commit(0);
        commit(169);
        chk("adv clear first", 14'hf4, {6'h0, level, param});
        commit(0);
        commit(3);
        chk("avg eight", 14'h3, {12'h0, averaging_count});
        commit(0);
        chk("hyst zero as one", 14'h1, hyst1);
        commit(2);
        chk("hyst2", 14'h2, hyst2);
        key(SFT, SHORT);
        chk("clear reads off", 14'h0, value);
        key(SFT, SHORT);
        key(UPK, SHORT);
        key(LVL, HOLD);
        chk("back to init", 14'h5, {10'h0, level});
        chk("edit dropped", 14'h3, {12'h0, averaging_count});
        key(LVL, HOLD);
        chk("back to oper", 14'h0, {10'h0, level});
    endtask
    task automatic t_clear();
        key(LVL, LONG);
        repeat (3) commit(0);
        commit(169);
        commit(1);
        chk("cleared", 14'h0, {7'h0, unit_f, act1, act2, averaging_count});
        chk("cleared hyst2", 14'h1, hyst2);
        key(LVL, HOLD);
        key(LVL, HOLD);
        chk("oper again", 14'h0, {10'h0, level});
    endtask
    task automatic t_variant();
        temp_v <= 1'b1;
        lock_z <= 1'b0;
        do_reset();
        key(LVL, LONG);
        commit(0);
        commit(0);
        chk("out2 hidden", 14'h3, {10'h0, param});
        commit(169);
        chk("clear hidden", 14'hf5, {6'h0, level, param});
        commit(0);
        commit(0);
        chk("hyst2 hidden", 14'h5, {10'h0, param});
    endtask
    initial begin
        #400_000;
        n_mismatch++;
        give_verdict();
    end
    initial begin
        do_reset();
        t_enter();
        t_init_pass();
        t_adv();
        t_clear();
        t_variant();
        give_verdict();
    end
endmodule
